// ===== rtl/dsi_defs.svh
`ifndef DSI_DEFS_SVH
`define DSI_DEFS_SVH
// Operation
// [RULE_01] standard, fast and high-speed clock rates supported
// [RULE_02] only 7-bit addresses; 10-bit sequences ignored
// [RULE_03] address is fixed 4-bit code plus 3-bit select
// [RULE_04] first byte after start is address plus direction
// [RULE_05] data falling while clock high is start
// [RULE_06] data changes only while clock is low
// [RULE_07] acknowledge by pulling data low on ninth clock
// [RULE_08] acknowledge own address and general call only
// [RULE_09] start after an error resets the sequencer
// [RULE_10] repeated start is handled exactly like start
// [RULE_11] data rising while clock high ends transfer
// [RULE_12] never hold the clock line low
// [RULE_13] malformed frame aborts without touching stored state
// [RULE_14] high-speed master code byte is never acknowledged
// [RULE_15] master code switches device into high-speed mode
// [RULE_16] stop leaves high-speed mode; repeated start keeps it
// [RULE_17] after the code, address byte then data bytes
// [RULE_18] general call reset and wake-up commands recognised
// [RULE_19] one general call command per call address
// [RULE_20] data sampled on each rising clock edge
// [RULE_21] start or stop mid-byte aborts, nothing delivered
// [RULE_22] general call is all-zero address with write
// [RULE_23] lines synchronised and filtered before edge detection

// ****************************************************************
// timing
// ****************************************************************
`define DSI_SYS_CLK_KHZ 125000
`define DSI_STD_KHZ 100
`define DSI_FAST_KHZ 400
`define DSI_HS_KHZ 3400
`define DSI_FILTER_SAMPLES 2

// ****************************************************************
// byte fields and codes
// ****************************************************************
`define DSI_BYTE_BITS 8
`define DSI_ACK_BIT 8
`define DSI_HS_PREFIX 5'h01
`define DSI_TENBIT_PREFIX 5'h1e
`define DSI_GC_BYTE 8'h00
`define DSI_GC_RESET 8'h06
`define DSI_GC_WAKE 8'h09
`define DSI_LINE_RESET 1'b1
`endif

// ===== rtl/dsi_pkg.sv
package dsi_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACK = 6'h04,
    S_DATA = 6'h08,
    S_DACK = 6'h10,
    S_SKIP = 6'h20
  } dsi_slv_e;
  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_COND = 4'h2,
    M_BYTE = 4'h4,
    M_DONE = 4'h8
  } dsi_mst_e;
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } dsi_cmd_e;
  typedef enum logic [1:0] {
    SPD_STD = 2'h0,
    SPD_FAST = 2'h1,
    SPD_HS = 2'h2
  } dsi_speed_e;
endpackage

// ===== rtl/dsi_if.sv
`timescale 1ns/1ps
interface dsi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // open-drain lines with pull-up: low wins
  assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
    output m_sda_o, output m_sda_oe);
  modport slave (input scl, input sda, output s_scl_o, output s_scl_oe,
    output s_sda_o, output s_sda_oe);
endinterface

// ===== rtl/dsi_filter.sv
`timescale 1ns/1ps
`include "dsi_defs.svh"
module dsi_filter #(
  parameter int SAMPLES = `DSI_FILTER_SAMPLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic line_i,
  output logic line_o
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic out_reg, out_next;
  logic [3:0] cnt_reg, cnt_next;

  // output follows only after SAMPLES equal synchronised samples
  always_comb
  begin
    meta_next = line_i;
    sync_next = meta_reg;
    out_next = out_reg;
    cnt_next = 4'h0;
    if (sync_reg != out_reg)
    begin
      if (cnt_reg == 4'(SAMPLES - 1))
        out_next = sync_reg; // [RULE_23]
      else
        cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta_reg <= `DSI_LINE_RESET;
      sync_reg <= `DSI_LINE_RESET;
      out_reg <= `DSI_LINE_RESET;
      cnt_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end

  assign line_o = out_reg;
endmodule

// ===== rtl/dsi_slave.sv
`timescale 1ns/1ps
`include "dsi_defs.svh"
module dsi_slave #(
  parameter logic [3:0] DEVICE_CODE = 4'h5, // arbitrary value
  parameter logic [7:0] GC_RESET_CODE = `DSI_GC_RESET,
  parameter logic [7:0] GC_WAKE_CODE = `DSI_GC_WAKE
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  dsi_if.slave bus,
  input wire logic [2:0] dev_sel_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic frame_abort_o,
  output logic gc_reset_o,
  output logic gc_wake_o,
  output logic hs_mode_o,
  output logic selected_o
);
  import dsi_pkg::*;

  // ****************************************************************
  // line conditioning and events
  // ****************************************************************
  logic scl_f, sda_f;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  dsi_filter #(.SAMPLES(`DSI_FILTER_SAMPLES)) u_scl_filter (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .line_i(bus.scl),
    .line_o(scl_f)
  );
  dsi_filter #(.SAMPLES(`DSI_FILTER_SAMPLES)) u_sda_filter (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .line_i(bus.sda),
    .line_o(sda_f)
  );

  assign scl_rise = scl_f & ~scl_d_reg;
  assign scl_fall = ~scl_f & scl_d_reg;
  assign start_ev = scl_f & scl_d_reg & sda_d_reg & ~sda_f; // [RULE_05]
  assign stop_ev = scl_f & scl_d_reg & ~sda_d_reg & sda_f; // [RULE_11]

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  dsi_slv_e state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rw_reg, rw_next;
  logic gc_reg, gc_next;
  logic gc_done_reg, gc_done_next;
  logic hs_reg, hs_next;
  logic sda_oe_reg, sda_oe_next;
  logic sel_done_reg, sel_done_next;
  logic [2:0] sel_reg, sel_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;
  logic abort_reg, abort_next;
  logic gc_reset_reg, gc_reset_next;
  logic gc_wake_reg, gc_wake_next;
  logic selected_reg, selected_next;
  logic mid_byte;

  // a condition inside a byte or an ack slot means a broken frame; the clock rise
  // that opens a stop or repeated start is already counted, so one bit is a clean end
  assign mid_byte = ((state_reg == S_ADDR || state_reg == S_DATA) && cnt_reg > 4'h1)
    || state_reg == S_ACK || state_reg == S_DACK;

  function automatic logic gc_cmd_known(input logic [7:0] b);
    gc_cmd_known = (b == GC_RESET_CODE) || (b == GC_WAKE_CODE);
  endfunction

  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    rw_next = rw_reg;
    gc_next = gc_reg;
    gc_done_next = gc_done_reg;
    hs_next = hs_reg;
    sda_oe_next = sda_oe_reg;
    sel_done_next = 1'b1;
    sel_next = sel_done_reg ? sel_reg : dev_sel_i;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    abort_next = 1'b0;
    gc_reset_next = 1'b0;
    gc_wake_next = 1'b0;
    selected_next = selected_reg;
    if (start_ev)
    begin
      // repeated start takes the same path and keeps high-speed mode
      abort_next = mid_byte; // [RULE_13] [RULE_21]
      state_next = S_ADDR; // [RULE_04] [RULE_09] [RULE_10] [RULE_16]
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
      gc_next = 1'b0;
      gc_done_next = 1'b0;
      selected_next = 1'b0;
    end
    else if (stop_ev)
    begin
      abort_next = mid_byte; // [RULE_13] [RULE_21]
      state_next = S_IDLE; // [RULE_11]
      hs_next = 1'b0; // [RULE_16]
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
      gc_next = 1'b0;
      gc_done_next = 1'b0;
      selected_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          cnt_next = 4'h0;
        end
        S_ADDR, S_DATA:
        begin
          if (scl_rise && cnt_reg != `DSI_ACK_BIT)
          begin
            shift_next = {shift_reg[6:0], sda_f}; // [RULE_20]
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == `DSI_ACK_BIT)
          begin
            cnt_next = 4'h0;
            state_next = S_SKIP;
            if (state_reg == S_ADDR)
            begin
              if (shift_reg[7:3] == `DSI_HS_PREFIX)
                hs_next = 1'b1; // [RULE_14] [RULE_15] [RULE_17]
              else if (shift_reg == `DSI_GC_BYTE)
              begin
                gc_next = 1'b1; // [RULE_22]
                sda_oe_next = 1'b1; // [RULE_08]
                rw_next = 1'b0;
                state_next = S_ACK;
              end
              else if (shift_reg[7:3] != `DSI_TENBIT_PREFIX
                && shift_reg[7:1] == {DEVICE_CODE, sel_reg}) // [RULE_02] [RULE_03]
              begin
                sda_oe_next = 1'b1; // [RULE_07] [RULE_08]
                rw_next = shift_reg[0];
                selected_next = 1'b1;
                state_next = S_ACK;
              end
            end
            else if (!gc_reg || (!gc_done_reg && gc_cmd_known(shift_reg))) // [RULE_19]
            begin
              sda_oe_next = 1'b1; // [RULE_07]
              gc_done_next = gc_reg;
              state_next = S_DACK;
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_next = 1'b0;
            // read payload is not served: the line stays released
            state_next = rw_reg ? S_SKIP : S_DATA;
          end
        end
        S_DACK:
        begin
          if (scl_fall)
          begin
            // delivery waits for the end of the ack so an abort delivers nothing
            sda_oe_next = 1'b0;
            state_next = S_DATA;
            if (gc_reg)
            begin
              gc_reset_next = (shift_reg == GC_RESET_CODE); // [RULE_18]
              gc_wake_next = (shift_reg == GC_WAKE_CODE); // [RULE_18]
            end
            else
            begin
              rx_data_next = shift_reg;
              rx_valid_next = 1'b1;
            end
          end
        end
        S_SKIP:
        begin
          sda_oe_next = 1'b0;
        end
        default:
        begin
          state_next = S_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      scl_d_reg <= `DSI_LINE_RESET;
      sda_d_reg <= `DSI_LINE_RESET;
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      gc_reg <= 1'b0;
      gc_done_reg <= 1'b0;
      hs_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sel_done_reg <= 1'b0;
      sel_reg <= 3'h0;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      abort_reg <= 1'b0;
      gc_reset_reg <= 1'b0;
      gc_wake_reg <= 1'b0;
      selected_reg <= 1'b0;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      rw_reg <= rw_next;
      gc_reg <= gc_next;
      gc_done_reg <= gc_done_next;
      hs_reg <= hs_next;
      sda_oe_reg <= sda_oe_next;
      sel_done_reg <= sel_done_next;
      sel_reg <= sel_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      abort_reg <= abort_next;
      gc_reset_reg <= gc_reset_next;
      gc_wake_reg <= gc_wake_next;
      selected_reg <= selected_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_reg;
  assign bus.s_scl_o = 1'b0;
  assign bus.s_scl_oe = 1'b0; // [RULE_12]
  assign rx_data_o = rx_data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign frame_abort_o = abort_reg;
  assign gc_reset_o = gc_reset_reg;
  assign gc_wake_o = gc_wake_reg;
  assign hs_mode_o = hs_reg; // [RULE_01]
  assign selected_o = selected_reg;
endmodule

// ===== rtl/dsi_master.sv
`timescale 1ns/1ps
`include "dsi_defs.svh"
module dsi_master (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  dsi_if.master bus,
  input wire logic cmd_valid_i,
  input wire dsi_pkg::dsi_cmd_e cmd_kind_i,
  input wire logic [7:0] cmd_data_i,
  input wire dsi_pkg::dsi_speed_e speed_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o
);
  import dsi_pkg::*;

  // quarter bit periods, rounded up so no rate is exceeded
  localparam logic [8:0] Q_STD =
    9'((`DSI_SYS_CLK_KHZ + 4 * `DSI_STD_KHZ - 1) / (4 * `DSI_STD_KHZ));
  localparam logic [8:0] Q_FAST =
    9'((`DSI_SYS_CLK_KHZ + 4 * `DSI_FAST_KHZ - 1) / (4 * `DSI_FAST_KHZ));
  localparam logic [8:0] Q_HS =
    9'((`DSI_SYS_CLK_KHZ + 4 * `DSI_HS_KHZ - 1) / (4 * `DSI_HS_KHZ));

  logic sda_f;
  dsi_filter #(.SAMPLES(1)) u_sda_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .line_i(bus.sda),
    .line_o(sda_f)
  );

  dsi_mst_e state_reg, state_next;
  dsi_cmd_e kind_reg, kind_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] phase_reg, phase_next;
  logic [8:0] div_reg, div_next;
  logic [8:0] quarter_reg, quarter_next;
  logic nack_req_reg, nack_req_next;
  logic scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic nack_reg, nack_next;
  logic tick;

  assign tick = (div_reg == 9'h000);

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    phase_next = phase_reg;
    div_next = tick ? quarter_reg - 9'h001 : div_reg - 9'h001;
    quarter_next = quarter_reg;
    nack_req_next = nack_req_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    done_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    nack_next = nack_reg;
    case (state_reg)
      M_IDLE:
      begin
        div_next = 9'h000;
        if (cmd_valid_i && ready_reg)
        begin
          kind_next = cmd_kind_i;
          shift_next = cmd_data_i;
          nack_req_next = cmd_data_i[0];
          bit_next = 4'h0;
          phase_next = 2'h0;
          case (speed_i)
            SPD_FAST: quarter_next = Q_FAST; // [RULE_01]
            SPD_HS: quarter_next = Q_HS; // [RULE_01]
            default: quarter_next = Q_STD; // [RULE_01]
          endcase
          div_next = quarter_next - 9'h001;
          state_next = (cmd_kind_i == CMD_START || cmd_kind_i == CMD_STOP) ? M_COND : M_BYTE;
        end
      end
      M_COND:
      begin
        if (tick)
        begin
          phase_next = phase_reg + 2'h1;
          // start: release data, raise clock, drop data, drop clock
          case (phase_reg)
            2'h0: sda_oe_next = (kind_reg == CMD_STOP);
            2'h1: scl_oe_next = 1'b0;
            2'h2: sda_oe_next = (kind_reg == CMD_START);
            default:
            begin
              scl_oe_next = (kind_reg == CMD_START);
              state_next = M_DONE;
            end
          endcase
        end
      end
      M_BYTE:
      begin
        if (tick)
        begin
          phase_next = phase_reg + 2'h1;
          case (phase_reg)
            2'h0:
            begin
              // data moves only in the low clock quarter
              if (bit_reg != `DSI_ACK_BIT)
                sda_oe_next = (kind_reg == CMD_WRITE) && !shift_reg[7]; // [RULE_06]
              else
                sda_oe_next = (kind_reg == CMD_READ) && !nack_req_reg; // [RULE_06]
            end
            2'h1: scl_oe_next = 1'b0;
            2'h2:
            begin
              if (bit_reg != `DSI_ACK_BIT)
                shift_next = {shift_reg[6:0], sda_f};
              else
                nack_next = sda_f;
            end
            default:
            begin
              scl_oe_next = 1'b1;
              if (bit_reg == `DSI_ACK_BIT)
                state_next = M_DONE;
              else
                bit_next = bit_reg + 4'h1;
            end
          endcase
        end
      end
      M_DONE:
      begin
        done_next = 1'b1;
        rsp_data_next = shift_reg;
        state_next = M_IDLE;
      end
      default:
      begin
        state_next = M_IDLE;
      end
    endcase
    ready_next = (state_next == M_IDLE) && !(state_reg == M_IDLE && cmd_valid_i && ready_reg);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= M_IDLE;
      kind_reg <= CMD_START;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      phase_reg <= 2'h0;
      div_reg <= 9'h000;
      quarter_reg <= Q_STD;
      nack_req_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      nack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      phase_reg <= phase_next;
      div_reg <= div_next;
      quarter_reg <= quarter_next;
      nack_req_reg <= nack_req_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      rsp_data_reg <= rsp_data_next;
      nack_reg <= nack_next;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_reg;
  assign cmd_ready_o = ready_reg;
  assign done_o = done_reg;
  assign rsp_data_o = rsp_data_reg;
  assign rsp_nack_o = nack_reg;
endmodule

// ===== verif/dsi_asserts.sv
`timescale 1ns/1ps
module dsi_asserts #(
  parameter logic [6:0] OWN_ADDR = 7'h2b
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_o,
  input wire logic m_sda_o,
  input wire logic s_scl_o,
  input wire logic s_scl_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  // ****************
  // wire-side bit tracking
  // ****************
  logic scl_reg, sda_reg, first_reg, first_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic rise, fall, start, stop;
  always_comb
  begin
    rise = scl & ~scl_reg;
    fall = ~scl & scl_reg;
    start = scl & scl_reg & sda_reg & ~sda;
    stop = scl & scl_reg & ~sda_reg & sda;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    first_next = first_reg;
    if (start | stop)
    begin
      cnt_next = 4'h0;
      first_next = start;
    end
    else if (rise)
    begin
      cnt_next = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
      shift_next = {shift_reg[6:0], sda};
      if (cnt_reg == 4'h9)
        first_next = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      first_reg <= 1'b0;
    end
    else
    begin
      scl_reg <= scl;
      sda_reg <= sda;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      first_reg <= first_next;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // ****************
  // properties
  // ****************
  property p_no_stretch;
    s_scl_oe == 1'b0;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("slave pulls clock");
  property p_open_drain;
    !(s_scl_o | s_sda_o | m_scl_o | m_sda_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_sda_scl_low;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved, clock high");
  property p_ack_slot;
    $rose(s_sda_oe) |-> cnt_reg == 4'h8 && !scl;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack outside ninth bit");
  property p_ack_release;
    $fell(s_sda_oe) |-> cnt_reg == 4'h9 && !scl;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack released early");
  property p_ack_hold;
    s_sda_oe && rise |=> s_sda_oe [*4];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped, clock high");
  property p_ack_addr;
    $rose(s_sda_oe) && first_reg |-> shift_reg[7:1] == OWN_ADDR || shift_reg == 8'h00;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("foreign address acked");
  property p_ack_own;
    first_reg && cnt_reg == 4'h8 && fall && shift_reg[7:1] == OWN_ADDR |-> ##[1:12] s_sda_oe;
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acked");
  property p_stop_idle;
    stop |=> !s_sda_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");
  c_ack: cover property ($rose(s_sda_oe) && first_reg);
  c_nack: cover property (first_reg && cnt_reg == 4'h8 && rise && sda);
  c_stop: cover property (stop);
endmodule

// ===== verif/dac_i2c_slave_interface_test.sv
`timescale 1ns/1ps
module dac_i2c_slave_interface_test;
  import dsi_pkg::*;
  localparam logic [3:0] DEV_CODE = 4'h5; // arbitrary value
  localparam logic [6:0] OWN_ADDR = {DEV_CODE, 3'h3};
  logic clk, rst, cmd_valid, cmd_ready, done, rsp_nack;
  logic rx_valid, frame_abort, gc_reset, gc_wake, hs_mode, selected;
  dsi_cmd_e cmd_kind;
  dsi_speed_e speed;
  logic [7:0] cmd_data, rsp_data, rx_data;
  int bad_count, comparisons, rx_count, rst_count, wake_count, abort_count;
  dsi_if u_dsi_if();
  dsi_master u_dsi_master(.sys_clk_i(clk), .reset_i(rst), .bus(u_dsi_if),
    .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_data_i(cmd_data),
    .speed_i(speed), .cmd_ready_o(cmd_ready), .done_o(done),
    .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
  dsi_slave #(.DEVICE_CODE(DEV_CODE)) u_dsi_slave(.sys_clk_i(clk), .reset_i(rst),
    .bus(u_dsi_if), .dev_sel_i(3'h3), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .frame_abort_o(frame_abort), .gc_reset_o(gc_reset), .gc_wake_o(gc_wake),
    .hs_mode_o(hs_mode), .selected_o(selected));
  dsi_asserts #(.OWN_ADDR(OWN_ADDR)) u_dsi_asserts(.sys_clk_i(clk), .reset_i(rst),
    .scl(u_dsi_if.scl), .sda(u_dsi_if.sda), .m_scl_o(u_dsi_if.m_scl_o),
    .m_sda_o(u_dsi_if.m_sda_o), .s_scl_o(u_dsi_if.s_scl_o),
    .s_scl_oe(u_dsi_if.s_scl_oe), .s_sda_o(u_dsi_if.s_sda_o),
    .s_sda_oe(u_dsi_if.s_sda_oe));
  // ****************
  // clock, monitors, checking
  // ****************
  initial
  begin
    clk = 1'b0;
    forever
      #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    rx_count += (rx_valid === 1'b1);
    rst_count += (gc_reset === 1'b1);
    wake_count += (gc_wake === 1'b1);
    abort_count += (frame_abort === 1'b1);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one command: request held for ready at most 8 cycles, then bounded wait for done
  task automatic cmd(input dsi_cmd_e kind, input logic [7:0] data, input dsi_speed_e spd);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= kind;
    cmd_data <= data;
    speed <= spd;
    for (n = 0; n < 8 && cmd_ready !== 1'b1; n++)
      @(posedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 12000 && done !== 1'b1; n++)
      @(posedge clk);
    check(done, 1'b1);
  endtask
  task automatic wr(input logic [7:0] b, input logic nack, input dsi_speed_e spd);
    cmd(CMD_WRITE, b, spd);
    check(rsp_nack, nack);
    // slave delivers a few cycles after the ack clock falls, after done
    repeat (8)
      @(posedge clk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_addr(input logic [7:0] b, input logic nack, input dsi_speed_e spd);
    cmd(CMD_START, 8'h00, spd);
    wr(b, nack, spd);
    check(selected, b[7:1] == OWN_ADDR);
    if (b == {OWN_ADDR, 1'b1})
    begin
      cmd(CMD_READ, 8'h01, spd);
      check(rsp_data, 8'hff);
    end
    cmd(CMD_STOP, 8'h00, spd);
    check(selected, 1'b0);
    $display("t_addr %h finished", b);
  endtask
  task automatic t_data();
    int base;
    cmd(CMD_START, 8'h00, SPD_FAST);
    wr({OWN_ADDR, 1'b0}, 1'b0, SPD_FAST);
    base = rx_count;
    wr(8'ha5, 1'b0, SPD_FAST);
    check(rx_data, 8'ha5);
    wr(8'h3c, 1'b0, SPD_FAST);
    check(rx_data, 8'h3c);
    cmd(CMD_START, 8'h00, SPD_FAST);
    check(selected, 1'b0);
    wr({OWN_ADDR, 1'b0}, 1'b0, SPD_FAST);
    check(selected, 1'b1);
    cmd(CMD_STOP, 8'h00, SPD_FAST);
    check(8'(rx_count - base), 8'h02);
    check(selected, 1'b0);
    $display("t_data finished");
  endtask
  task automatic t_hs();
    cmd(CMD_START, 8'h00, SPD_FAST);
    wr(8'h0b, 1'b1, SPD_FAST);
    check(hs_mode, 1'b1);
    cmd(CMD_START, 8'h00, SPD_HS);
    check(hs_mode, 1'b1);
    wr({OWN_ADDR, 1'b0}, 1'b0, SPD_HS);
    wr(8'h5a, 1'b0, SPD_HS);
    check(rx_data, 8'h5a);
    cmd(CMD_STOP, 8'h00, SPD_HS);
    check(hs_mode, 1'b0);
    $display("t_hs finished");
  endtask
  task automatic t_gc(input logic [7:0] code, input logic [7:0] n_rst, input logic [7:0] n_wake);
    int r0, w0;
    r0 = rst_count;
    w0 = wake_count;
    cmd(CMD_START, 8'h00, SPD_FAST);
    wr(8'h00, 1'b0, SPD_FAST);
    wr(code, 1'b0, SPD_FAST);
    wr(code ^ 8'h0f, 1'b1, SPD_FAST);
    cmd(CMD_STOP, 8'h00, SPD_FAST);
    check(8'(rst_count - r0), n_rst);
    check(8'(wake_count - w0), n_wake);
    $display("t_gc %h finished", code);
  endtask
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = CMD_START;
    cmd_data = 8'h00;
    speed = SPD_FAST;
    repeat (4)
      @(posedge clk);
    rst <= 1'b0;
    t_addr({OWN_ADDR, 1'b0}, 1'b0, SPD_STD);
    t_addr({OWN_ADDR ^ 7'h01, 1'b0}, 1'b1, SPD_FAST);
    t_addr({OWN_ADDR ^ 7'h40, 1'b0}, 1'b1, SPD_FAST);
    t_addr(8'hf2, 1'b1, SPD_FAST);
    t_addr(8'h01, 1'b1, SPD_FAST);
    t_addr({OWN_ADDR, 1'b1}, 1'b0, SPD_FAST);
    t_data();
    t_hs();
    t_gc(8'h06, 8'h01, 8'h00);
    t_gc(8'h09, 8'h00, 8'h01);
    check(8'(abort_count), 8'h00);
    stop_test();
  end
  // about 90k cycles: above the expected run of roughly 70k cycles
  initial
  begin
    #720_000;
    bad_count++;
    stop_test();
  end
endmodule
